/* File: cmd_fifo.sv */
// Purpose: Small instruction buffer with honest full and empty.
// Assumes: Single clock, synchronous active-high reset.
// Notes: Depth is a parameter; the slots are not reset.
`timescale 1ns/1ps
module cmd_fifo
  import eeprom_pkg::*;
#(
  parameter int DEPTH = CMD_DEPTH
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  cmd_stream_if.snk fillPort,
  cmd_stream_if.src drainPort
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [PW:0] FULL_COUNT = (PW + 1)'(DEPTH);

  cmd_t slots [DEPTH];
  logic [PW-1:0] wrPtr_q, wrPtr_d, rdPtr_q, rdPtr_d;
  logic [PW:0] count_q, count_d;
  logic push, pop;

  function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
    bump = (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  assign fillPort.ready = (count_q != FULL_COUNT);
  assign drainPort.valid = (count_q != '0);
  assign drainPort.data = slots[rdPtr_q];

  always_comb begin
    push = fillPort.valid && fillPort.ready;
    pop = drainPort.valid && drainPort.ready;
    wrPtr_d = push ? bump(wrPtr_q) : wrPtr_q;
    rdPtr_d = pop ? bump(rdPtr_q) : rdPtr_q;
    count_d = count_q;
    if (push && !pop) begin
      count_d = count_q + 1'b1;
    end else if (pop && !push) begin
      count_d = count_q - 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
    end else begin
      wrPtr_q <= wrPtr_d;
      rdPtr_q <= rdPtr_d;
      count_q <= count_d;
    end
    if (push) begin
      slots[wrPtr_q] <= fillPort.data;
    end
  end
endmodule // cmd_fifo

/* File: cmd_stream_if.sv */
// Purpose: Valid/ready carrier for decoded instructions.
// Assumes: Transfer happens on a clock edge with valid and ready both high.
// Notes: Used between the shifter, the buffer and the executor.
`timescale 1ns/1ps
interface cmd_stream_if;
  import eeprom_pkg::*;
  logic valid;
  logic ready;
  cmd_t data;
  modport src(output valid, output data, input ready);
  modport snk(input valid, input data, output ready);
endinterface

/* File: eeprom_pkg.sv */
// Purpose: Shared constants and types of the serial EEPROM command port.
// Assumes: Sixteen registers of sixteen bits, nine-bit instructions.
// Notes: Op codes and state codes live here only.
package eeprom_pkg;
  localparam int WORD_W = 16;
  localparam int ADDR_W = 4;
  localparam int REG_COUNT = 16;
  localparam int CMD_DEPTH = 2;
  localparam logic [1:0] GRP_CTL = 2'h0;
  localparam logic [1:0] GRP_WRITE = 2'h1;
  localparam logic [1:0] GRP_READ = 2'h2;
  localparam logic [1:0] GRP_ERASE = 2'h3;
  localparam logic [3:0] OP_PROG_DISABLE = 4'h0;
  localparam logic [3:0] OP_WRITE_ALL = 4'h1;
  localparam logic [3:0] OP_ERASE_ALL = 4'h2;
  localparam logic [3:0] OP_PROG_ENABLE = 4'h3;
  localparam logic [15:0] ERASED_WORD = 16'hFFFF;
  localparam logic [4:0] HDR_LAST = 5'h07;
  localparam logic [4:0] DATA_LAST = 5'h0F;
  localparam logic [4:0] READ_END = 5'h10;
  localparam logic [2:0] SYNC_RESET = 3'h0;
  // Host-side timing, kept for reference by the bench; the device does not time it.
  localparam int PROGRAM_TIME_MIN_MS = 5;
  localparam int PROGRAM_TIME_MAX_MS = 30;
  localparam int CS_LOW_MIN_US = 1;

  typedef struct packed {
    logic [3:0] op;
    logic [3:0] addr;
    logic [15:0] data;
  } cmd_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_HDR = 3'b001,
    ST_DATA = 3'b011,
    ST_READ = 3'b101,
    ST_DONE = 3'b111
  } shift_state_t;
endpackage

/* File: serial_eeprom_port.sv */
// Purpose: Serial command port and 16x16 cell array of a serial EEPROM.
// Assumes: Pins are asynchronous to ref_clk and are sampled through two flops.
// Notes: Programming lasts while chip select stays low after an instruction.
`timescale 1ns/1ps
module serial_eeprom_port
  import eeprom_pkg::*;
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic chipSelect,
  input wire logic serialClock,
  input wire logic serialIn,
  output logic serialOut,
  output logic serialOutEn_n,
  output logic programVoltage,
  output logic programEnabled
);
  cmd_stream_if fillBus();
  cmd_stream_if drainBus();

  logic [1:0] csSync_q, csSync_d, sckSync_q, sckSync_d, dinSync_q, dinSync_d;
  logic csPrev_q, sckPrev_q;
  logic csHigh, csFall, sckRise, din;
  shift_state_t st_q, st_d;
  logic [4:0] cnt_q, cnt_d;
  logic [7:0] hdr_q, hdr_d;
  logic [15:0] data_q, data_d, outSh_q, outSh_d;
  logic out_q, out_d, oeN_q, oeN_d;
  logic pushValid, rdLoad;
  logic [15:0] mem_q [REG_COUNT];
  logic [15:0] mem_d [REG_COUNT];
  logic en_q, en_d, prog_q, prog_d;
  logic popFire, isCtl, memWe;
  cmd_t cmd;

  function automatic logic needsData(input logic [3:0] op);
    needsData = (op[3:2] == GRP_WRITE) || (op == OP_WRITE_ALL);
  endfunction

  // Only the second stage of each synchroniser is read by logic.
  assign csHigh = csSync_q[1];
  assign din = dinSync_q[1];
  assign sckRise = sckSync_q[1] && !sckPrev_q;
  assign csFall = !csSync_q[1] && csPrev_q;

  always_comb begin
    csSync_d = {csSync_q[0], chipSelect};
    sckSync_d = {sckSync_q[0], serialClock};
    dinSync_d = {dinSync_q[0], serialIn};
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      csSync_q <= SYNC_RESET[1:0];
      sckSync_q <= SYNC_RESET[1:0];
      dinSync_q <= SYNC_RESET[1:0];
      csPrev_q <= 1'b0;
      sckPrev_q <= 1'b0;
    end else begin
      csSync_q <= csSync_d;
      sckSync_q <= sckSync_d;
      dinSync_q <= dinSync_d;
      csPrev_q <= csSync_q[1];
      sckPrev_q <= sckSync_q[1];
    end
  end

  // Instruction shifter and read-out path.
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    hdr_d = hdr_q;
    data_d = data_q;
    outSh_d = outSh_q;
    out_d = out_q;
    oeN_d = oeN_q;
    pushValid = 1'b0;
    rdLoad = 1'b0;
    if (!csHigh) begin
      st_d = ST_IDLE;
      oeN_d = 1'b1;
    end else if (sckRise) begin
      case (st_q)
        ST_IDLE: begin
          if (din) begin
            st_d = ST_HDR;
            cnt_d = '0;
          end
        end
        ST_HDR: begin
          hdr_d = {hdr_q[6:0], din};
          cnt_d = cnt_q + 1'b1;
          if (cnt_q == HDR_LAST) begin
            cnt_d = '0;
            if (hdr_d[7:6] == GRP_READ) begin
              st_d = ST_READ;
              outSh_d = mem_q[hdr_d[3:0]];
              out_d = 1'b0;
              oeN_d = 1'b0;
              rdLoad = 1'b1;
            end else if (needsData(hdr_d[7:4])) begin
              st_d = ST_DATA;
            end else begin
              pushValid = 1'b1;
              st_d = ST_DONE;
            end
          end
        end
        ST_DATA: begin
          data_d = {data_q[14:0], din};
          cnt_d = cnt_q + 1'b1;
          if (cnt_q == DATA_LAST) begin
            pushValid = 1'b1;
            st_d = ST_DONE;
          end
        end
        ST_READ: begin
          cnt_d = cnt_q + 1'b1;
          if (cnt_q == READ_END) begin
            st_d = ST_DONE;
            oeN_d = 1'b1;
          end else begin
            out_d = outSh_q[15];
            outSh_d = {outSh_q[14:0], 1'b0};
          end
        end
        ST_DONE: begin
          st_d = ST_DONE;
        end
        default: begin
          st_d = ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      st_q <= ST_IDLE;
      cnt_q <= '0;
      hdr_q <= '0;
      data_q <= '0;
      outSh_q <= '0;
      out_q <= 1'b0;
      oeN_q <= 1'b1;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      hdr_q <= hdr_d;
      data_q <= data_d;
      outSh_q <= outSh_d;
      out_q <= out_d;
      oeN_q <= oeN_d;
    end
  end

  // A command refused by a full buffer is dropped; it cannot fill in practice.
  assign fillBus.valid = pushValid;
  assign fillBus.data = cmd_t'{op: hdr_d[7:4], addr: hdr_d[3:0], data: data_d};

  cmd_fifo #(
    .DEPTH(CMD_DEPTH)
  ) cmdBuffer (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .fillPort(fillBus),
    .drainPort(drainBus)
  );

  // Executor: control ops act at once, program ops wait for the select fall.
  assign cmd = drainBus.data;
  assign isCtl = (cmd.op == OP_PROG_ENABLE) || (cmd.op == OP_PROG_DISABLE);
  assign popFire = drainBus.valid && (isCtl || csFall);
  assign drainBus.ready = popFire;

  always_comb begin
    mem_d = mem_q;
    en_d = en_q;
    prog_d = prog_q;
    memWe = 1'b0;
    if (prog_q && csHigh) begin
      prog_d = 1'b0;
    end
    if (popFire) begin
      if (cmd.op == OP_PROG_ENABLE) begin
        en_d = 1'b1;
      end else if (cmd.op == OP_PROG_DISABLE) begin
        en_d = 1'b0;
      end else if (en_q) begin
        prog_d = 1'b1;
        memWe = 1'b1;
        case (cmd.op[3:2])
          GRP_WRITE: begin
            mem_d[cmd.addr] = mem_q[cmd.addr] & cmd.data;
          end
          GRP_ERASE: begin
            mem_d[cmd.addr] = ERASED_WORD;
          end
          default: begin
            for (int i = 0; i < REG_COUNT; i++) begin
              mem_d[i] = (cmd.op == OP_ERASE_ALL) ? ERASED_WORD : cmd.data;
            end
          end
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      en_q <= 1'b0;
      prog_q <= 1'b0;
      for (int i = 0; i < REG_COUNT; i++) begin
        mem_q[i] <= ERASED_WORD;
      end
    end else begin
      en_q <= en_d;
      prog_q <= prog_d;
      mem_q <= mem_d;
    end
  end

  assign serialOut = out_q;
  assign serialOutEn_n = oeN_q;
  assign programVoltage = prog_q;
  assign programEnabled = en_q;

  AST_OUT_RELEASE: assert property (
    @(posedge ref_clk) disable iff (sys_rst) !csHigh |=> serialOutEn_n)
    else $error("Serial output still driven with select low.");

  AST_READ_DUMMY: assert property (
    @(posedge ref_clk) disable iff (sys_rst) rdLoad |=> (!serialOutEn_n && !serialOut))
    else $error("Read did not start with a driven zero.");

  AST_OUT_ON_RISE: assert property (
    @(posedge ref_clk) disable iff (sys_rst) $changed(serialOut) |-> $past(sckRise))
    else $error("Serial output changed away from a clock rise.");

  AST_WRITE_GATED: assert property (
    @(posedge ref_clk) disable iff (sys_rst) memWe |-> en_q)
    else $error("Cell written while programming disabled.");

  AST_ERASE_ONES: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    (memWe && cmd.op[3:2] == GRP_ERASE) |=> (mem_q[$past(cmd.addr)] == ERASED_WORD))
    else $error("Erased register is not all ones.");

  AST_CYCLE_END: assert property (
    @(posedge ref_clk) disable iff (sys_rst) (prog_q && csHigh) |=> !prog_q)
    else $error("Programming cycle outlived select rise.");

  AST_HV_START: assert property (
    @(posedge ref_clk) disable iff (sys_rst) $rose(prog_q) |-> $past(csFall && en_q))
    else $error("Programming voltage rose without a select fall.");

  AST_ENABLE_CMD: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    (popFire && cmd.op == OP_PROG_ENABLE) |=> en_q)
    else $error("Enable command did not set the enable state.");

  AST_START_WAIT: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    (st_q == ST_IDLE && csHigh && sckRise && !din) |=> (st_q == ST_IDLE))
    else $error("Left idle without a start bit.");

  AST_ERASE_ALL: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    (memWe && cmd.op == OP_ERASE_ALL) |=> (mem_q[0] == ERASED_WORD && mem_q[15] == ERASED_WORD))
    else $error("Erase-all left a register not all ones.");
endmodule // serial_eeprom_port

/* File: serial_host_model.sv */
// Purpose: Host controller model that drives the serial pins of the EEPROM port.
// Assumes: Pins change 1 ns after a ref_clk rise; serial clock idles low outside frames.
// Notes: A serial clock phase lasts 4 ref_clk cycles, a 160 ns period.
`timescale 1ns/1ps
module serial_host_model (
  input wire logic ref_clk,
  output logic chipSelect,
  output logic serialClock,
  output logic serialIn,
  input wire logic serialOut,
  input wire logic serialOutEn_n
);
  initial begin
    chipSelect = 1'b0;
    serialClock = 1'b0;
    serialIn = 1'b0;
  end

  task automatic idle(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic select(input logic v, input int n);
    chipSelect = v;
    idle(n);
  endtask

  // frame shifting
  // Output is sampled late in the low phase, away from its change while the clock is high.
  task automatic shiftFrame(input logic [26:0] bits, input int n, output logic [16:0] got,
                            output logic [16:0] oeSeen);
    got = '0;
    oeSeen = '0;
    chipSelect = 1'b1;
    for (int i = n - 1; i >= 0; i--) begin
      serialIn = bits[i];
      idle(4);
      // A released pin reads as the inverse of the last level, so an undriven bit cannot pass.
      got = {got[15:0], serialOutEn_n ? ~serialOut : serialOut};
      oeSeen = {oeSeen[15:0], serialOutEn_n};
      serialClock = 1'b1;
      idle(4);
      serialClock = 1'b0;
    end
    serialIn = ~serialIn;
  endtask
endmodule // serial_host_model

/* File: tb_top.sv */
// Purpose: Self-checking bench of the serial EEPROM command port.
// Assumes: Host model drives the pins; cells come out of reset erased.
// Notes: Programming pulses are shortened to keep the run brief.
`timescale 1ns/1ps
module tb_top;
  import eeprom_pkg::*;
  // Shortened stand-in for the multi-millisecond programming pulse.
  // host pulse length
  localparam int PROG_HOLD = 40;
  localparam int CS_GAP = 60;
  logic ref_clk;
  logic sys_rst;
  logic chipSelect;
  logic serialClock;
  logic serialIn;
  logic serialOut;
  logic serialOutEn_n;
  logic programVoltage;
  logic programEnabled;
  int mismatches;
  int checks;

  serial_eeprom_port DUT (.ref_clk(ref_clk), .sys_rst(sys_rst), .chipSelect(chipSelect),
    .serialClock(serialClock), .serialIn(serialIn), .serialOut(serialOut),
    .serialOutEn_n(serialOutEn_n), .programVoltage(programVoltage),
    .programEnabled(programEnabled));

  serial_host_model host (.ref_clk(ref_clk), .chipSelect(chipSelect),
    .serialClock(serialClock), .serialIn(serialIn), .serialOut(serialOut),
    .serialOutEn_n(serialOutEn_n));

  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // A leading zero clock precedes the start bit on every read.
  task automatic readReg(input logic [3:0] op, input logic [3:0] addr, input logic [15:0] exp);
    logic [16:0] got;
    logic [16:0] oe;
    host.shiftFrame({1'b0, 1'b1, op, addr, 17'h0}, 27, got, oe);
    check({15'h0, got[16]}, 16'h0000);
    check(got[15:0], exp);
    check(oe[15:0], 16'h0000);
    check({15'h0, oe[16]}, 16'h0000);
    host.select(1'b0, CS_GAP);
    check({15'h0, serialOutEn_n}, 16'h0001);
  endtask

  task automatic progOp(input logic [3:0] op, input logic [3:0] addr, input logic [15:0] data,
                        input bit hasData, input logic expV);
    logic [16:0] g;
    logic [16:0] o;
    if (hasData)
      host.shiftFrame({2'b00, 1'b1, op, addr, data}, 25, g, o);
    else
      host.shiftFrame({18'h0, 1'b1, op, addr}, 9, g, o);
    host.select(1'b0, 6);
    check({15'h0, programVoltage}, {15'h0, expV});
    check({15'h0, serialOutEn_n}, 16'h0001);
    host.idle(PROG_HOLD);
    check({15'h0, programVoltage}, {15'h0, expV});
    host.select(1'b1, 6);
    check({15'h0, programVoltage}, 16'h0000);
    host.idle(2);
    host.select(1'b0, CS_GAP);
  endtask

  task automatic ctlOp(input logic [3:0] op, input logic expEn);
    logic [16:0] g;
    logic [16:0] o;
    host.shiftFrame({18'h0, 1'b1, op, 4'hA}, 9, g, o);
    host.select(1'b0, CS_GAP);
    check({15'h0, programEnabled}, {15'h0, expEn});
  endtask

  task automatic test_reset();
    check({13'h0, serialOutEn_n, programVoltage, programEnabled}, 16'h0004);
    readReg(4'h8, 4'h3, ERASED_WORD);
    $display("test_reset done");
  endtask

  task automatic test_refused();
    progOp(4'h4, 4'h3, 16'h1234, 1'b1, 1'b0);
    progOp(OP_WRITE_ALL, 4'h0, 16'h0000, 1'b1, 1'b0);
    readReg(4'h9, 4'h3, ERASED_WORD);
    readReg(4'hA, 4'h0, ERASED_WORD);
    $display("test_refused done");
  endtask

  task automatic test_single();
    ctlOp(OP_PROG_ENABLE, 1'b1);
    progOp(4'h7, 4'h5, 16'hA5C3, 1'b1, 1'b1);
    readReg(4'hB, 4'h5, 16'hA5C3);
    progOp(4'h4, 4'h5, 16'h0F0F, 1'b1, 1'b1);
    readReg(4'h8, 4'h5, 16'h0503);
    progOp(4'hE, 4'h5, 16'h0000, 1'b0, 1'b1);
    readReg(4'h8, 4'h5, ERASED_WORD);
    readReg(4'h8, 4'h4, ERASED_WORD);
    $display("test_single done");
  endtask

  task automatic test_bulk();
    progOp(OP_WRITE_ALL, 4'h6, 16'h1357, 1'b1, 1'b1);
    readReg(4'h8, 4'h0, 16'h1357);
    readReg(4'h8, 4'hF, 16'h1357);
    progOp(OP_ERASE_ALL, 4'h6, 16'h0000, 1'b0, 1'b1);
    readReg(4'h8, 4'hF, ERASED_WORD);
    progOp(4'h5, 4'h9, 16'h00F0, 1'b1, 1'b1);
    ctlOp(OP_PROG_DISABLE, 1'b0);
    progOp(4'hC, 4'h9, 16'h0000, 1'b0, 1'b0);
    readReg(4'h8, 4'h9, 16'h00F0);
    $display("test_bulk done");
  endtask

  initial begin
    repeat (60000) @(posedge ref_clk);
    mismatches++;
    tally_and_finish();
  end

  initial begin
    mismatches = 0;
    checks = 0;
    sys_rst = 1'b1;
    repeat (4) @(posedge ref_clk);
    #1;
    sys_rst = 1'b0;
    host.idle(4);
    test_reset();
    test_refused();
    test_single();
    test_bulk();
    tally_and_finish();
  end
endmodule // tb_top
